// ===== src/light_power_integ_ctrl.sv
// power, converter enable and integration period control with its command decode
// assumes the serial front end hands over whole bytes with a transaction-start mark
`timescale 1ns/1ps

// Overview of operation
// - control register bit 5 reads 1 while the interrupt is being driven
// - control register bit 4 reads 1 once an integration cycle has finished
// - converter enable 1 starts integration on both channels, 0 disables them
// - power bit 1 powers the device on, 0 turns it off
// - control resets to zero; reserved bits 7:6 and 3:2 written as zero
// - period register sets automatic integration in 2.7 ms intervals
// - period value is two's complement of interval count; ff is one
// - period 01 gives the longest integration, 255 intervals, 688.5 ms
// - period 00 selects manual integration under host start and stop
// - period register resets to zero, so manual mode after power on
// - the first byte of a transaction with its top bit set is taken as a command byte
// - with period zero, special function 00011 starts manual integration
// - with period zero, special function 00010 stops it; length readable
// - special function 00001 clears the pending interrupt and its flag
module light_power_integ_ctrl #(
   parameter int INTERVAL_CYCLES = light_ctrl_pkg::INTERVAL_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // byte port from the serial front end
   input wire logic host_frame_start,
   input wire logic host_wr_valid,
   input wire logic [7:0] host_wr_byte,
   input wire logic host_rd_req,
   output logic [7:0] rd_data_q,
   // interrupt logic alongside
   input wire logic intr_raise,
   output logic interrupt_pending_flag_q,
   output logic intr_clear_q,
   // converter side
   output logic power_on_q,
   output logic conv_enable_q,
   output logic conv_valid_q,
   output logic integrating_q,
   output logic conv_done_q,
   output logic [7:0] integration_period_value_q,
   output logic [light_ctrl_pkg::MAN_TICKS_W-1:0] manual_ticks_q
);
   import light_ctrl_pkg::*;

   // ****************************************
   // command and data decode
   // ****************************************
   logic [4:0] addr_q;
   logic [1:0] trans_q;
   logic cmd_byte;
   logic data_wr;
   logic special;
   logic [1:0] byte_trans;
   logic [4:0] byte_code;
   logic ctl_wr;
   logic per_wr;
   logic manual_mode;
   logic [7:0] control_view;
   logic [7:0] rd_mux;
   logic done_kept;

   integ_seq_if seq_link ();

   assign byte_trans = host_wr_byte[CMD_TRANS_HI:CMD_TRANS_LO];
   assign byte_code = host_wr_byte[4:0];

   // first byte of a transaction with the top bit set is a command
   assign cmd_byte = host_wr_valid && host_frame_start
      && host_wr_byte[CMD_SELECT_BIT];
   assign data_wr = host_wr_valid && !cmd_byte;
   assign special = cmd_byte && (byte_trans == TRANS_SPECIAL);
   assign ctl_wr = data_wr && (addr_q == ADDR_CONTROL);
   assign per_wr = data_wr && (addr_q == ADDR_PERIOD);
   assign manual_mode = (integration_period_value_q == PERIOD_MANUAL);

   // address pointer and transaction type, stepping on auto-increment
   // a special command leaves the pointer where it was
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         addr_q <= ADDR_CONTROL;
         trans_q <= TRANS_REPEAT;
      end else if (cmd_byte) begin
         trans_q <= byte_trans;
         if (byte_trans != TRANS_SPECIAL) begin
            addr_q <= byte_code;
         end
      end else if ((data_wr || host_rd_req) && trans_q == TRANS_AUTOINC) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   // ****************************************
   // control and period registers
   // ****************************************

   // power and converter enable; reserved bits are not stored
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         power_on_q <= CONTROL_RESET[CTL_POWER_BIT];
         conv_enable_q <= CONTROL_RESET[CTL_ENABLE_BIT];
      end else if (ctl_wr) begin
         power_on_q <= host_wr_byte[CTL_POWER_BIT];
         conv_enable_q <= host_wr_byte[CTL_ENABLE_BIT];
      end
   end

   // integration period, zero at reset selects manual mode
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         integration_period_value_q <= PERIOD_RESET;
      end else if (per_wr) begin
         integration_period_value_q <= host_wr_byte;
      end
   end

   // ****************************************
   // status flags
   // ****************************************

   // interrupt pending: a raise in the clearing cycle wins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         interrupt_pending_flag_q <= 1'b0;
         intr_clear_q <= 1'b0;
      end else begin
         intr_clear_q <= special && (byte_code == SF_INT_CLEAR);
         if (intr_raise) begin
            interrupt_pending_flag_q <= 1'b1;
         end else if (special && byte_code == SF_INT_CLEAR) begin
            interrupt_pending_flag_q <= 1'b0;
         end
      end
   end

   // valid: set on completion, cleared when converter is switched off
   // a completion aborted by the same switch-off never sets it
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         conv_valid_q <= 1'b0;
      end else if (done_kept) begin
         conv_valid_q <= 1'b1;
      end else if (!(power_on_q && conv_enable_q)) begin
         conv_valid_q <= 1'b0;
      end
   end

   // ****************************************
   // sequencer hookup
   // ****************************************

   // conversions only run with both power and enable set
   assign seq_link.run = power_on_q && conv_enable_q;
   assign seq_link.period = integration_period_value_q;
   assign seq_link.man_start = special && manual_mode
      && (byte_code == SF_MAN_START);
   assign seq_link.man_stop = special && manual_mode
      && (byte_code == SF_MAN_STOP);

   light_integ_seq #(
      .INTERVAL_CYCLES(INTERVAL_CYCLES)
   ) u_seq (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .s(seq_link.seq)
   );

   // a completion that lands in the cycle the converter is switched off counts as aborted,
   // so neither the done pulse nor the valid flag comes out of it
   assign done_kept = seq_link.done && seq_link.run;

   // registered copies of sequencer status
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         integrating_q <= 1'b0;
         conv_done_q <= 1'b0;
         manual_ticks_q <= '0;
      end else begin
         integrating_q <= seq_link.integrating;
         conv_done_q <= done_kept;
         manual_ticks_q <= seq_link.man_ticks;
      end
   end

   // ****************************************
   // read path
   // ****************************************

   // control register view: reserved bits read as zero
   // bits 5 and 4 are status and cannot be written
   always_comb begin
      control_view = 8'h00;
      control_view[CTL_POWER_BIT] = power_on_q;
      control_view[CTL_ENABLE_BIT] = conv_enable_q;
      control_view[CTL_VALID_BIT] = conv_valid_q;
      control_view[CTL_INTR_BIT] = interrupt_pending_flag_q;
   end

   // register select; other addresses belong elsewhere and read zero here
   always_comb begin
      case (addr_q)
         ADDR_CONTROL: rd_mux = control_view;
         ADDR_PERIOD: rd_mux = integration_period_value_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // read data captured on request
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rd_data_q <= 8'h00;
      end else if (host_rd_req) begin
         rd_data_q <= rd_mux;
      end
   end

endmodule

// ===== src/light_ctrl_pkg.sv
// constants, field layout and state codes of the light sensor power and integration control
// assumes a 10 MHz system clock and a byte-level host port from the serial front end
package light_ctrl_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [4:0] ADDR_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_PERIOD = 5'h01;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'h00;

   // control register field positions
   localparam int CTL_POWER_BIT = 0;
   localparam int CTL_ENABLE_BIT = 1;
   localparam int CTL_VALID_BIT = 4;
   localparam int CTL_INTR_BIT = 5;

   // ****************************************
   // command byte layout
   // ****************************************
   localparam int CMD_SELECT_BIT = 7;
   localparam int CMD_TRANS_HI = 6;
   localparam int CMD_TRANS_LO = 5;
   localparam logic [1:0] TRANS_REPEAT = 2'h0;
   localparam logic [1:0] TRANS_AUTOINC = 2'h1;
   localparam logic [1:0] TRANS_SPECIAL = 2'h3;
   localparam logic [4:0] SF_INT_CLEAR = 5'h01;
   localparam logic [4:0] SF_MAN_STOP = 5'h02;
   localparam logic [4:0] SF_MAN_START = 5'h03;

   // ****************************************
   // integration timing
   // ****************************************
   localparam logic [7:0] PERIOD_MANUAL = 8'h00;
   localparam logic [7:0] PERIOD_WRAP = 8'hff;
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int INTERVAL_TIME_US = 2700;
   localparam int INTERVAL_CYCLES = INTERVAL_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int MAN_TICKS_W = 16;

   // integration sequencer states
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h1,
      SEQ_AUTO = 3'h2,
      SEQ_MANUAL = 3'h4
   } seq_state_e;

endpackage

// ===== src/integ_seq_if.sv
// signals between the register front end and the integration sequencer
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface integ_seq_if;
   import light_ctrl_pkg::*;
   logic run;
   logic [7:0] period;
   logic man_start;
   logic man_stop;
   logic done;
   logic integrating;
   logic [MAN_TICKS_W-1:0] man_ticks;

   modport ctrl (output run, output period, output man_start, output man_stop,
                 input done, input integrating, input man_ticks);
   modport seq (input run, input period, input man_start, input man_stop,
                output done, output integrating, output man_ticks);
endinterface

// ===== src/light_integ_seq.sv
// integration sequencer: interval tick divider, automatic counter, manual timer
// assumes run, period and the start/stop pulses are synchronous to sys_clk
`timescale 1ns/1ps
module light_integ_seq #(
   parameter int INTERVAL_CYCLES = light_ctrl_pkg::INTERVAL_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // link to the register front end
   integ_seq_if.seq s
);
   import light_ctrl_pkg::*;

   localparam int DIV_W = $clog2(INTERVAL_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INTERVAL_CYCLES - 1);

   seq_state_e state_q, state_d;
   logic [DIV_W-1:0] div_q;
   logic [7:0] integration_interval_count_q;
   logic tick;
   logic wrap;

   // one-cycle enable every interval while integrating
   assign tick = (state_q != SEQ_IDLE) && (div_q == DIV_LAST);
   assign wrap = tick && (integration_interval_count_q == PERIOD_WRAP);

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         SEQ_IDLE: begin
            if (s.run && s.period != PERIOD_MANUAL) begin
               state_d = SEQ_AUTO;
            end else if (s.run && s.man_start) begin
               state_d = SEQ_MANUAL;
            end
         end
         SEQ_AUTO: begin
            if (!s.run || s.period == PERIOD_MANUAL) begin
               state_d = SEQ_IDLE;
            end
         end
         SEQ_MANUAL: begin
            if (!s.run || s.man_stop) begin
               state_d = SEQ_IDLE;
            end
         end
         default: state_d = SEQ_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= SEQ_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // interval divider, held at zero when idle so each start is aligned
   always_ff @(posedge sys_clk) begin
      if (!reset_n || state_d == SEQ_IDLE || state_q == SEQ_IDLE) begin
         div_q <= '0;
      end else if (div_q == DIV_LAST) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // automatic interval counter: load period, count up, end on wrap past ff
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         integration_interval_count_q <= PERIOD_RESET;
      end else if (state_q == SEQ_IDLE || wrap) begin
         integration_interval_count_q <= s.period;
      end else if (tick) begin
         integration_interval_count_q <= integration_interval_count_q + 1'b1;
      end
   end

   // manual integration timer, saturating, held after stop for readback
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s.man_ticks <= '0;
      end else if (state_q == SEQ_IDLE && state_d == SEQ_MANUAL) begin
         s.man_ticks <= '0;
      end else if (state_q == SEQ_MANUAL && tick && s.man_ticks != '1) begin
         s.man_ticks <= s.man_ticks + 1'b1;
      end
   end

   // completion pulse and busy level
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s.done <= 1'b0;
         s.integrating <= 1'b0;
      end else begin
         s.done <= (state_q == SEQ_AUTO && state_d == SEQ_AUTO && wrap)
            || (state_q == SEQ_MANUAL && s.run && s.man_stop);
         s.integrating <= (state_d != SEQ_IDLE);
      end
   end

endmodule

// ===== dv/light_ctrl_checker.sv
// assertions on the ports of the power and integration control block
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module light_ctrl_checker #(
   parameter int INTERVAL_CYCLES = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // host and interrupt inputs
   input wire logic host_wr_valid,
   input wire logic intr_raise,
   // block outputs
   input wire logic interrupt_pending_flag_q,
   input wire logic intr_clear_q,
   input wire logic power_on_q,
   input wire logic conv_enable_q,
   input wire logic conv_valid_q,
   input wire logic integrating_q,
   input wire logic conv_done_q,
   input wire logic [7:0] integration_period_value_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // registers come out of reset cleared
   chk_reset_clear: assert property ($rose(reset_n) |->
      !power_on_q && !conv_enable_q && integration_period_value_q == 8'h00)
      else $error("registers not clear after reset");
   // control and period only move after a written byte
   chk_write_change: assert property (
      !$stable({power_on_q, conv_enable_q, integration_period_value_q}) |-> $past(host_wr_valid))
      else $error("register changed without a write");
   // a raised interrupt shows in the pending flag
   chk_intr_set: assert property (intr_raise |=> interrupt_pending_flag_q)
      else $error("pending flag not set");
   // the clear command drops the flag
   chk_intr_clear: assert property (
      intr_clear_q && !$past(intr_raise) |-> ##[0:1] !interrupt_pending_flag_q)
      else $error("pending flag not cleared");
   // valid only while powered and enabled
   chk_valid_run: assert property (!(power_on_q && conv_enable_q) |=> !conv_valid_q)
      else $error("valid held while stopped");
   // stopping aborts the integration
   chk_integ_stop: assert property (
      !(power_on_q && conv_enable_q) |-> ##[1:3] !integrating_q)
      else $error("integration not aborted");
   // end of integration is a single pulse and sets valid
   chk_done_pulse: assert property (conv_done_q |-> conv_valid_q ##1 !conv_done_q)
      else $error("done pulse malformed");
   // period ff gives one interval between ends
   chk_auto_len: assert property (conv_done_q && integration_period_value_q == 8'hff
      |-> ##[INTERVAL_CYCLES:INTERVAL_CYCLES] (conv_done_q || !conv_enable_q))
      else $error("one interval length wrong");
endmodule

bind light_power_integ_ctrl light_ctrl_checker #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .host_wr_valid(host_wr_valid),
   .intr_raise(intr_raise), .interrupt_pending_flag_q(interrupt_pending_flag_q),
   .intr_clear_q(intr_clear_q), .power_on_q(power_on_q), .conv_enable_q(conv_enable_q),
   .conv_valid_q(conv_valid_q), .integrating_q(integrating_q), .conv_done_q(conv_done_q),
   .integration_period_value_q(integration_period_value_q));

// ===== dv/light_host_model.sv
// host model: hands bytes and read requests to the block's byte port
// assumes callers run on sys_clk; requests change just after a rising edge
`timescale 1ns/1ps
module light_host_model (
   // clock
   input wire logic sys_clk,
   // byte port
   output logic host_frame_start,
   output logic host_wr_valid,
   output logic [7:0] host_wr_byte,
   output logic host_rd_req,
   input wire logic [7:0] rd_data_q
);
   // port quiet at time zero
   initial begin
      host_frame_start = 1'b0;
      host_wr_valid = 1'b0;
      host_wr_byte = 8'h00;
      host_rd_req = 1'b0;
   end
   // one byte, held until the next edge takes it
   task automatic put(input logic first, input logic [7:0] b);
      @(posedge sys_clk);
      host_frame_start <= first;
      host_wr_valid <= 1'b1;
      host_wr_byte <= b;
   endtask
   // release the port
   task automatic idle();
      @(posedge sys_clk);
      host_frame_start <= 1'b0;
      host_wr_valid <= 1'b0;
      host_wr_byte <= ~host_wr_byte;
      host_rd_req <= 1'b0;
   endtask
   // command byte then data byte, never a data byte first in a frame
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      put(1'b1, {3'b100, a});
      put(1'b0, d);
      idle();
   endtask
   // auto-increment command then two data bytes to consecutive registers
   task automatic wr2(input logic [4:0] a, input logic [7:0] d0, input logic [7:0] d1);
      put(1'b1, {3'b101, a});
      put(1'b0, d0);
      put(1'b0, d1);
      idle();
   endtask
   // special function command
   task automatic cmd(input logic [4:0] code);
      put(1'b1, {3'b111, code});
      idle();
   endtask
   // point at a register and read it
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      put(1'b1, {3'b100, a});
      @(posedge sys_clk);
      host_wr_valid <= 1'b0;
      host_frame_start <= 1'b0;
      host_wr_byte <= ~host_wr_byte;
      host_rd_req <= 1'b1;
      idle();
      @(negedge sys_clk);
      d = rd_data_q;
   endtask
   // power first, wait the settle time, then enable
   task automatic start(input int settle);
      wr(5'h00, 8'h01);
      repeat (settle) @(posedge sys_clk);
      wr(5'h00, 8'h03);
   endtask
endmodule

// ===== dv/test_light_power_integ_ctrl.sv
// self-checking bench for the power and integration control block
// assumes a 10 MHz clock and the host model on the byte port
`timescale 1ns/1ps
module test_light_power_integ_ctrl;
   import light_ctrl_pkg::*;
   localparam int IC = 4;
   logic sys_clk, reset_n, host_frame_start, host_wr_valid, host_rd_req, intr_raise;
   logic interrupt_pending_flag_q, intr_clear_q, power_on_q, conv_enable_q;
   logic conv_valid_q, integrating_q, conv_done_q;
   logic [7:0] host_wr_byte, rd_data_q, integration_period_value_q, rd_val;
   logic [MAN_TICKS_W-1:0] manual_ticks_q;
   int fails, n_checks, n;

   // block under test and the host in front of it
   light_power_integ_ctrl #(.INTERVAL_CYCLES(IC)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .host_frame_start(host_frame_start), .host_wr_valid(host_wr_valid),
      .host_wr_byte(host_wr_byte), .host_rd_req(host_rd_req), .rd_data_q(rd_data_q),
      .intr_raise(intr_raise), .interrupt_pending_flag_q(interrupt_pending_flag_q),
      .intr_clear_q(intr_clear_q), .power_on_q(power_on_q), .conv_enable_q(conv_enable_q),
      .conv_valid_q(conv_valid_q), .integrating_q(integrating_q), .conv_done_q(conv_done_q),
      .integration_period_value_q(integration_period_value_q), .manual_ticks_q(manual_ticks_q));
   light_host_model model (.sys_clk(sys_clk), .host_frame_start(host_frame_start),
      .host_wr_valid(host_wr_valid), .host_wr_byte(host_wr_byte),
      .host_rd_req(host_rd_req), .rd_data_q(rd_data_q));

   // 100 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // compare one byte result
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // report and stop
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // let register updates land
   task automatic settle();
      repeat (3) @(negedge sys_clk);
   endtask
   // bounded wait for the end-of-integration pulse
   task automatic wait_done(output int k);
      k = 0;
      while (conv_done_q !== 1'b1 && k < 1100) begin
         @(negedge sys_clk);
         k++;
      end
      if (k >= 1100) begin
         fails++;
         $display("Error at %0t: no end-of-integration pulse", $time);
         give_verdict();
      end
   endtask
   // reset values and an unmapped address
   task automatic t_reset();
      model.rd(ADDR_CONTROL, rd_val);
      check(rd_val, CONTROL_RESET);
      model.rd(ADDR_PERIOD, rd_val);
      check(rd_val, PERIOD_RESET);
      model.rd(5'h02, rd_val);
      check(rd_val, 8'h00);
   endtask
   // reserved and read-only control bits are not stored
   task automatic t_ctrl();
      model.start(20000);
      model.wr(ADDR_CONTROL, 8'hf3);
      model.rd(ADDR_CONTROL, rd_val);
      check(rd_val, 8'h03);
      check({7'h0, integrating_q}, 8'h00);
   endtask
   // automatic periods: one, two and the longest interval count
   task automatic t_auto();
      logic [7:0] p[3];
      p = '{8'hff, 8'hfe, 8'h01};
      for (int i = 0; i < 3; i++) begin
         model.wr(ADDR_CONTROL, 8'h01);
         settle();
         check({7'h0, conv_valid_q}, 8'h00);
         model.wr(ADDR_PERIOD, p[i]);
         model.wr(ADDR_CONTROL, 8'h03);
         wait_done(n);
         @(negedge sys_clk);
         wait_done(n);
         check(8'(n + 1 == (256 - int'(p[i])) * IC), 8'h01);
      end
      model.rd(ADDR_CONTROL, rd_val);
      check(rd_val, 8'h13);
      model.wr(ADDR_CONTROL, 8'h01);
      settle();
      check({7'h0, integrating_q}, 8'h00);
   endtask
   // manual integration under start and stop commands
   task automatic t_manual();
      model.wr(ADDR_PERIOD, PERIOD_MANUAL);
      model.wr(ADDR_CONTROL, 8'h03);
      settle();
      check({7'h0, integrating_q}, 8'h00);
      model.cmd(SF_MAN_START);
      settle();
      check({7'h0, integrating_q}, 8'h01);
      repeat (3 * IC) @(posedge sys_clk);
      model.cmd(SF_MAN_STOP);
      settle();
      check({6'h0, integrating_q, conv_valid_q}, 8'h01);
      check(8'(manual_ticks_q >= 3 && manual_ticks_q <= 5), 8'h01);
   endtask
   // pending flag set, read back and cleared
   task automatic t_intr();
      @(posedge sys_clk);
      intr_raise <= 1'b1;
      @(posedge sys_clk);
      intr_raise <= 1'b0;
      model.rd(ADDR_CONTROL, rd_val);
      check(rd_val & 8'h20, 8'h20);
      model.cmd(SF_INT_CLEAR);
      @(negedge sys_clk);
      check({7'h0, intr_clear_q}, 8'h01);
      settle();
      check({7'h0, interrupt_pending_flag_q}, 8'h00);
      check({7'h0, intr_clear_q}, 8'h00);
      model.wr2(ADDR_CONTROL, 8'h00, 8'hfe);
      model.rd(ADDR_PERIOD, rd_val);
      check(rd_val, 8'hfe);
      model.rd(ADDR_CONTROL, rd_val);
      check(rd_val, 8'h00);
   endtask
   // main sequence
   initial begin
      fails = 0;
      n_checks = 0;
      reset_n = 1'b0;
      intr_raise = 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_ctrl();
      t_auto();
      t_manual();
      t_intr();
      give_verdict();
   end
endmodule
